/* pkg/exc_cfg.svh */
// Constants for the exception sequencer: vector numbers, fixed addresses,
// reset values and pin timing.
// Assumes a 32-bit core with byte addresses and a 4-bit interrupt mask.
// How it works
// RQ1 - Pending sources served singly, reset first
// RQ2 - Reset starts on pin rise; NMI picks type
// RQ3 - Address errors, interrupts wait for instruction end
// RQ4 - Trap starts when trap executes
// RQ5 - Undefined opcode outside slot: general illegal
// RQ6 - Slot undefined or PC-writer: illegal slot
// RQ7 - Power-on reset reads PC@0, SP@4
// RQ8 - Manual reset reads PC@8, SP@12
// RQ9 - Reset clears vector base, mask all ones
// RQ10 - Push status then PC via stack_gpr, jump
// RQ11 - Interrupt writes level to mask; others keep
// RQ12 - Reset vector*4; others base plus vector*4
// RQ13 - Vectors 4, 6, traps 32 to 63
// RQ14 - Vector 9 CPU, 10 DMA address error
// RQ15 - NMI 11, break 12, lines 64-71
// RQ16 - Manual reset spares bus, pin, port state
// RQ17 - Reset pin held low twenty clocks
// RQ18 - Manual reset never aborts bus cycle
// RQ19 - Odd or peripheral-region fetch is error
// RQ20 - Misaligned word or long data is error
// RQ21 - Long access to 8-bit peripheral errors
// RQ22 - Stack next PC; undelayed handler branch
// RQ23 - NMI accepted loads mask fifteen
// RQ24 - Trap vector from immediate, PC after trap
// RQ25 - Each vector entry one 32-bit read
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH
`define VEC_GEN_ILLEGAL  8'h04
`define VEC_SLOT_ILLEGAL 8'h06
`define VEC_CPU_ADDR_ERR 8'h09
`define VEC_DMA_ADDR_ERR 8'h0a
`define VEC_NMI          8'h0b
`define VEC_USER_BREAK   8'h0c
`define VEC_EXT_INT_BASE 8'h40
`define ADDR_POR_PC      32'h00000000
`define ADDR_POR_SP      32'h00000004
`define ADDR_MAN_PC      32'h00000008
`define ADDR_MAN_SP      32'h0000000c
`define VECTOR_BASE_RST  32'h00000000
`define MASK_RESET       4'hf
`define MASK_NMI         4'hf
`define NMI_LEVEL        5'h10
`define RESET_LOW_MIN    20
`endif

/* pkg/exc_pkg.sv */
// Types shared by the exception sequencer and its surroundings.
// Assumes the constants header is compiled alongside.
package exc_pkg;
    typedef enum logic [3:0] {
        st_idle      = 4'h0,
        st_rst_pc    = 4'h1,
        st_rst_sp    = 4'h2,
        st_wait_end  = 4'h3,
        st_push_sr   = 4'h4,
        st_push_pc   = 4'h5,
        st_fetch_vec = 4'h6,
        st_jump      = 4'h7
    } seq_state_t;

    typedef enum logic [1:0] {
        sz_byte = 2'h0,
        sz_word = 2'h1,
        sz_long = 2'h2
    } access_size_t;

    typedef struct packed {
        logic         valid;
        logic         is_fetch;
        logic         is_dma;
        access_size_t size;
        logic [31:0]  addr;
    } bus_check_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        seq_state_t  state;
        logic        reset_pin_q;
        logic        manual;
        logic [31:0] vector_base;
        logic [3:0]  int_mask_level;
        logic [7:0]  vector;
        logic        is_int;
        logic [3:0]  int_level;
        logic [31:0] saved_pc;
        logic [31:0] saved_sr;
        logic [31:0] sp;
        logic [31:0] new_pc;
        logic        load_pc;
        logic        load_sp;
        logic        manual_out;
        logic        busy;
        mem_req_t    mem;
    } exc_state_t;
endpackage : exc_pkg

/* hw/cpu_exception_sequencer.sv */
// Exception sequencer of the core: detects, orders and runs exceptions.
// Assumes a memory port that answers each request with mem_ack, and a
// decode stage that reports instruction boundaries and decode flags.
`timescale 1ns/1ns
`include "exc_cfg.svh"
module cpu_exception_sequencer #(
    parameter logic [31:0] PERIPH_BASE  = 32'h05000000,
    parameter logic [31:0] PERIPH_MASK  = 32'hff000000,
    parameter logic [31:0] PERIPH8_BASE = 32'h05fffe00,
    parameter logic [31:0] PERIPH8_MASK = 32'hffffff00
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              reset_pin_n,
    input  wire logic              nmi_pin,
    input  wire logic              nmi_req,
    input  wire logic              user_break_req,
    input  wire logic              irq_req,
    input  wire logic [3:0]        irq_level,
    input  wire logic [7:0]        irq_vector,
    input  wire exc_pkg::bus_check_t bus_check,
    input  wire logic              bus_cycle_done,
    input  wire logic              insn_boundary,
    input  wire logic              decode_valid,
    input  wire logic              decode_undefined,
    input  wire logic              decode_pc_write,
    input  wire logic              decode_in_slot,
    input  wire logic              trap_exec,
    input  wire logic [7:0]        trap_imm,
    input  wire logic [31:0]       next_pc_in,
    input  wire logic [31:0]       decode_pc,
    input  wire logic [31:0]       slot_target_pc,
    input  wire logic [31:0]       status_word,
    input  wire logic [31:0]       stack_gpr,
    input  wire logic              vbr_write,
    input  wire logic [31:0]       vbr_wdata,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    output exc_pkg::mem_req_t      mem,
    output logic                   busy,
    output logic                   load_pc,
    output logic                   load_sp,
    output logic [31:0]            new_pc,
    output logic [31:0]            new_sp,
    output logic [31:0]            vector_base,
    output logic [3:0]             int_mask_level,
    output logic                   manual_reset,
    output logic                   addr_error
);
    exc_pkg::exc_state_t s;
    exc_pkg::exc_state_t next_s;
    logic                cpu_ae_pend;
    logic                dma_ae_pend;
    logic                next_cpu_ae;
    logic                next_dma_ae;
    logic                ae_now;
    logic                in_p;

    // RQ19 RQ20 RQ21 alignment and region check.
    always_comb begin
        in_p = (bus_check.addr & PERIPH_MASK) == PERIPH_BASE;
        ae_now = 1'b0;
        if (bus_check.valid) begin
            if (bus_check.is_fetch) begin
                ae_now = bus_check.addr[0] | in_p;
            end else if (bus_check.size == exc_pkg::sz_word) begin
                ae_now = bus_check.addr[0];
            end else if (bus_check.size == exc_pkg::sz_long) begin
                ae_now = (bus_check.addr[1:0] != 2'h0) | (in_p &&
                    ((bus_check.addr & PERIPH8_MASK) == PERIPH8_BASE));
            end
        end
    end

    always_comb begin
        next_s = s;
        next_cpu_ae = cpu_ae_pend;
        next_dma_ae = dma_ae_pend;
        next_s.load_pc = 1'b0;
        next_s.load_sp = 1'b0;
        next_s.reset_pin_q = reset_pin_n;
        if (vbr_write && !s.busy) begin
            next_s.vector_base = vbr_wdata;
        end
        // RQ1 RQ2 reset outranks all, rising pin edge starts it.
        if (!reset_pin_n) begin
            next_s.busy = 1'b1;
            next_s.manual = !nmi_pin;
            next_s.state = exc_pkg::st_idle;
            // RQ18 manual reset lets open cycle finish.
            next_s.mem.req = !nmi_pin && s.mem.req && !mem_ack;
            next_cpu_ae = 1'b0;
            next_dma_ae = 1'b0;
            // RQ9 RQ16 core state cleared for both kinds.
            next_s.vector_base = `VECTOR_BASE_RST;
            next_s.int_mask_level = `MASK_RESET;
        end else if (!s.reset_pin_q) begin
            // RQ7 RQ8 RQ12 RQ25 reset PC read, no base.
            next_s.state = exc_pkg::st_rst_pc;
            next_s.manual_out = s.manual;
            next_s.mem.req = 1'b1;
            next_s.mem.write = 1'b0;
            next_s.mem.addr = s.manual ? `ADDR_MAN_PC : `ADDR_POR_PC;
        end else begin
            case (s.state)
                exc_pkg::st_idle: begin
                    next_s.busy = 1'b0;
                    // RQ4 RQ24 RQ13 trap at execution.
                    if (trap_exec) begin
                        next_s.vector = trap_imm;
                        next_s.saved_pc = next_pc_in;
                        next_s.is_int = 1'b0;
                        next_s.busy = 1'b1;
                        next_s.state = exc_pkg::st_push_sr;
                    end else if (decode_valid && (cpu_ae_pend ||
                        dma_ae_pend || nmi_req || user_break_req ||
                        (irq_req && irq_level > s.int_mask_level))) begin
                        // RQ3 RQ22 wait for the running instruction.
                        next_s.busy = 1'b1;
                        next_s.state = exc_pkg::st_wait_end;
                    end else if (decode_valid && decode_in_slot &&
                        (decode_undefined || decode_pc_write)) begin
                        // RQ6 slot exception at decode.
                        next_s.vector = `VEC_SLOT_ILLEGAL;
                        next_s.saved_pc = slot_target_pc;
                        next_s.is_int = 1'b0;
                        next_s.busy = 1'b1;
                        next_s.state = exc_pkg::st_push_sr;
                    end else if (decode_valid && decode_undefined) begin
                        // RQ5 general illegal at decode.
                        next_s.vector = `VEC_GEN_ILLEGAL;
                        next_s.saved_pc = decode_pc;
                        next_s.is_int = 1'b0;
                        next_s.busy = 1'b1;
                        next_s.state = exc_pkg::st_push_sr;
                    end
                end
                exc_pkg::st_wait_end: begin
                    // RQ18 RQ22 bus cycle and instruction finish first.
                    if (insn_boundary && bus_cycle_done) begin
                        next_s.saved_pc = next_pc_in;
                        next_s.state = exc_pkg::st_push_sr;
                        next_s.is_int = 1'b0;
                        // RQ1 RQ14 address errors before interrupts.
                        if (cpu_ae_pend) begin
                            next_s.vector = `VEC_CPU_ADDR_ERR;
                            next_cpu_ae = 1'b0;
                        end else if (dma_ae_pend) begin
                            next_s.vector = `VEC_DMA_ADDR_ERR;
                            next_dma_ae = 1'b0;
                        end else if (nmi_req) begin
                            // RQ15 RQ23 NMI vector, mask fifteen.
                            next_s.vector = `VEC_NMI;
                            next_s.is_int = 1'b1;
                            next_s.int_level = `MASK_NMI;
                        end else if (user_break_req) begin
                            next_s.vector = `VEC_USER_BREAK;
                            next_s.is_int = 1'b1;
                            next_s.int_level = 4'hf;
                        end else if (irq_req &&
                            irq_level > s.int_mask_level) begin
                            next_s.vector = irq_vector;
                            next_s.is_int = 1'b1;
                            next_s.int_level = irq_level;
                        end else begin
                            next_s.state = exc_pkg::st_idle;
                        end
                    end
                end
                exc_pkg::st_push_sr: begin
                    // RQ10 status word pushed first.
                    next_s.saved_sr = status_word;
                    next_s.sp = stack_gpr - 32'h4;
                    next_s.mem.req = 1'b1;
                    next_s.mem.write = 1'b1;
                    next_s.mem.addr = stack_gpr - 32'h4;
                    next_s.mem.wdata = {status_word[31:8],
                        s.int_mask_level, status_word[3:0]};
                    next_s.state = exc_pkg::st_push_pc;
                end
                exc_pkg::st_push_pc: begin
                    if (mem_ack) begin
                        // RQ10 program counter pushed second.
                        next_s.sp = s.sp - 32'h4;
                        next_s.mem.addr = s.sp - 32'h4;
                        next_s.mem.wdata = s.saved_pc;
                        next_s.state = exc_pkg::st_fetch_vec;
                    end
                end
                exc_pkg::st_fetch_vec: begin
                    if (mem_ack) begin
                        // RQ12 RQ25 handler address base plus vector*4.
                        next_s.mem.write = 1'b0;
                        next_s.mem.addr = s.vector_base +
                            {22'h0, s.vector, 2'h0};
                        next_s.state = exc_pkg::st_jump;
                        // RQ11 only interrupts change the mask.
                        if (s.is_int) begin
                            next_s.int_mask_level = s.int_level;
                        end
                    end
                end
                exc_pkg::st_jump: begin
                    if (mem_ack) begin
                        // RQ22 non-delayed branch to handler.
                        next_s.mem.req = 1'b0;
                        next_s.new_pc = mem_rdata;
                        next_s.load_pc = 1'b1;
                        next_s.load_sp = 1'b1;
                        next_s.state = exc_pkg::st_idle;
                    end
                end
                exc_pkg::st_rst_pc: begin
                    if (mem_ack) begin
                        next_s.new_pc = mem_rdata;
                        next_s.mem.addr = s.manual_out ?
                            `ADDR_MAN_SP : `ADDR_POR_SP;
                        next_s.state = exc_pkg::st_rst_sp;
                    end
                end
                exc_pkg::st_rst_sp: begin
                    if (mem_ack) begin
                        // RQ7 load PC and SP, then run.
                        next_s.mem.req = 1'b0;
                        next_s.sp = mem_rdata;
                        next_s.load_pc = 1'b1;
                        next_s.load_sp = 1'b1;
                        next_s.state = exc_pkg::st_idle;
                    end
                end
                default: begin
                    next_s.state = exc_pkg::st_idle;
                end
            endcase
        end
        // RQ19 RQ20 new error beats same-cycle clear.
        if (ae_now && reset_pin_n && !bus_check.is_dma) begin
            next_cpu_ae = 1'b1;
        end
        if (ae_now && reset_pin_n && bus_check.is_dma) begin
            next_dma_ae = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.reset_pin_q <= 1'b1;
            s.int_mask_level <= `MASK_RESET;
            s.busy <= 1'b1;
            cpu_ae_pend <= 1'b0;
            dma_ae_pend <= 1'b0;
        end else if (clk_en) begin
            s <= next_s;
            cpu_ae_pend <= next_cpu_ae;
            dma_ae_pend <= next_dma_ae;
        end
    end

    assign mem = s.mem;
    assign busy = s.busy;
    assign load_pc = s.load_pc;
    assign load_sp = s.load_sp;
    assign new_pc = s.new_pc;
    assign new_sp = s.sp;
    assign vector_base = s.vector_base;
    assign int_mask_level = s.int_mask_level;
    assign manual_reset = s.manual_out;
    assign addr_error = cpu_ae_pend | dma_ae_pend;
endmodule : cpu_exception_sequencer

/* verification/vec_mem_model.sv */
// Memory model answering vector and stack accesses; read data is derived from the address and writes are not stored.
// Assumes requests stay up until acknowledged; slow adds wait cycles.
`timescale 1ns/1ns
module vec_mem_model (
    input  wire logic              mclk,
    input  wire exc_pkg::mem_req_t mem,
    input  wire logic              slow,
    output logic                   mem_ack,
    output logic [31:0]            mem_rdata
);
    logic [1:0] wait_cnt;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
        wait_cnt = 2'h0;
    end
    always @(posedge mclk) begin
        if (mem.req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
            mem_ack <= 1'b1;
            mem_rdata <= {4'h1, mem.addr[23:0], 4'h0};
            wait_cnt <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt <= mem.req ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule : vec_mem_model

/* verification/exc_seq_chk.sv */
// Checker watching the ports of the exception sequencer.
// Assumes the bind below and a stable stack register during a push.
`timescale 1ns/1ns
module exc_seq_chk (
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic              reset_pin_n,
    input wire logic              nmi_pin,
    input wire logic [31:0]       stack_gpr,
    input wire exc_pkg::mem_req_t mem,
    input wire logic              mem_ack,
    input wire logic              busy,
    input wire logic              load_pc,
    input wire logic [31:0]       vector_base,
    input wire logic [3:0]        int_mask_level
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_req_held: assert property (
        mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
        else $error("memory request changed before ack");
    a_reset_init: assert property (
        !reset_pin_n ##1 !reset_pin_n |->
        int_mask_level == 4'hf && vector_base == 32'h0)
        else $error("reset did not set mask and base");
    a_por_fetch: assert property (
        $rose(reset_pin_n) && nmi_pin |->
        ##[1:2] mem.req && !mem.write && mem.addr == 32'h0)
        else $error("power-on reset did not read address 0");
    a_man_fetch: assert property (
        $rose(reset_pin_n) && !nmi_pin |->
        ##[1:2] mem.req && !mem.write && mem.addr == 32'h8)
        else $error("manual reset did not read address 8");
    a_sp_after_pc: assert property (
        mem.req && mem_ack && !mem.write &&
        (mem.addr == 32'h0 || mem.addr == 32'h8) |=>
        mem.req && mem.addr == $past(mem.addr) + 32'h4)
        else $error("stack value not read after program counter");
    a_push_order: assert property (
        mem.req && mem_ack && mem.write && mem.addr == stack_gpr - 32'h4
        |=> mem.req && mem.write && mem.addr == stack_gpr - 32'h8)
        else $error("counter push did not follow status push");
    a_load_late: assert property (
        load_pc |-> $past(mem_ack) && !mem.req)
        else $error("load without a finished read");
    a_load_pulse: assert property (
        load_pc |=> !load_pc)
        else $error("load pulse longer than one cycle");
    a_idle_mask: assert property (
        !busy && reset_pin_n |=> busy || $stable(int_mask_level))
        else $error("mask changed while idle");
    c_push: cover property (mem.req && mem_ack && mem.write);
    c_load: cover property (load_pc);
    c_start: cover property ($rose(busy));
endmodule : exc_seq_chk
bind cpu_exception_sequencer exc_seq_chk i_chk (.mclk, .reset,
    .reset_pin_n, .nmi_pin, .stack_gpr, .mem, .mem_ack, .busy,
    .load_pc, .vector_base, .int_mask_level);

/* verification/tb_top.sv */
// Self-checking bench for the exception sequencer.
// Assumes the memory model answers every request.
`timescale 1ns/1ns
`include "exc_cfg.svh"
module tb_top;
    logic mclk, reset, reset_pin_n, nmi_pin, nmi_req, irq_req, slow;
    logic decode_valid, decode_undefined, decode_pc_write, decode_in_slot;
    logic trap_exec, vbr_write, mem_ack, busy, load_pc, manual_reset, done;
    logic user_break_req, addr_error, load_sp;
    logic [3:0] irq_level, int_mask_level;
    logic [7:0] irq_vector, trap_imm;
    logic [31:0] next_pc_in, decode_pc, slot_target_pc, status_word;
    logic [31:0] stack_gpr, vbr_wdata, mem_rdata, new_pc, new_sp;
    logic [31:0] vector_base, pushed_pc, base;
    exc_pkg::bus_check_t bus_check;
    exc_pkg::bus_check_t acc [4];
    logic [7:0] acc_vec [4];
    exc_pkg::mem_req_t mem;
    integer seed, fails, total_checks, cyc;
    cpu_exception_sequencer i_dut (.mclk, .reset, .clk_en(1'b1),
        .reset_pin_n, .nmi_pin, .nmi_req, .user_break_req, .irq_req,
        .irq_level, .irq_vector, .bus_check, .bus_cycle_done(done),
        .insn_boundary(done), .decode_valid, .decode_undefined,
        .decode_pc_write, .decode_in_slot, .trap_exec, .trap_imm,
        .next_pc_in, .decode_pc, .slot_target_pc, .status_word, .stack_gpr,
        .vbr_write, .vbr_wdata, .mem_ack, .mem_rdata, .mem, .busy, .load_pc,
        .load_sp, .new_pc, .new_sp, .vector_base, .int_mask_level,
        .manual_reset, .addr_error);
    vec_mem_model i_mem (.mclk, .mem, .slow, .mem_ack, .mem_rdata);
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {4'h1, a[23:0], 4'h0};
    endfunction : word_at
    task automatic give_verdict;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_load(input string nm, input logic [31:0] pc, sp);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        while (load_pc !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(nm, {30'h0, load_sp, load_pc}, 32'h3);
        chk(nm, new_pc, pc);
        chk(nm, new_sp, sp);
        $display("test %s done", nm);
    endtask : wait_load
    task automatic pin_reset(input logic nmi);
        @(posedge mclk);
        nmi_pin <= nmi;
        reset_pin_n <= 1'b0;
        repeat (`RESET_LOW_MIN) @(posedge mclk);
        reset_pin_n <= 1'b1;
        wait_load("reset", word_at({28'h0, ~nmi, 3'h0}),
            word_at({28'h0, ~nmi, 3'h4}));
        chk("type", 32'(manual_reset), 32'(!nmi));
        chk("base", vector_base, 32'h0);
    endtask : pin_reset
    task automatic shuffle;
        @(posedge mclk);
        slow <= ~slow;
        next_pc_in <= $random(seed) & 32'hfffffffe;
        decode_pc <= $random(seed) & 32'hfffffffe;
        slot_target_pc <= $random(seed) & 32'hfffffffe;
        stack_gpr <= 32'h00100000 | ($random(seed) & 32'h000ffffc);
        status_word <= $random(seed) | 32'hf0;
    endtask : shuffle
    task automatic decode(input logic u, w, s);
        @(posedge mclk);
        decode_undefined <= u;
        decode_pc_write <= w;
        decode_in_slot <= s;
        decode_valid <= 1'b1;
        @(posedge mclk);
        decode_valid <= 1'b0;
    endtask : decode
    task automatic exc(input string nm, input logic [7:0] v,
                       input logic [31:0] pc);
        wait_load(nm, word_at(base + {22'h0, v, 2'h0}),
            stack_gpr - 32'h8);
        chk("stacked pc", pushed_pc, pc);
    endtask : exc
    always @(posedge mclk) begin
        cyc++;
        if (mem.req && mem_ack && mem.write && mem.addr == stack_gpr - 32'h8)
            pushed_pc <= mem.wdata;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        {nmi_req, irq_req, slow, decode_valid, trap_exec, vbr_write} = '0;
        user_break_req = 1'b0;
        {decode_undefined, decode_pc_write, decode_in_slot} = '0;
        {irq_level, irq_vector, trap_imm, vbr_wdata, pushed_pc} = '0;
        {next_pc_in, decode_pc, slot_target_pc, status_word} = '0;
        {seed, fails, total_checks, cyc} = '0;
        {reset, reset_pin_n, nmi_pin, done, stack_gpr} = {4'hf, 32'h1000};
        bus_check = '0;
        seed = 99;
        base = 32'h00002000;
        acc = '{'{1'b1, 1'b1, 1'b0, exc_pkg::sz_word, 32'h00001001},
                '{1'b1, 1'b0, 1'b1, exc_pkg::sz_long, 32'h00003002},
                '{1'b1, 1'b0, 1'b0, exc_pkg::sz_long, 32'h05fffe04},
                '{1'b1, 1'b0, 1'b0, exc_pkg::sz_long, 32'h05000004}};
        acc_vec = '{`VEC_CPU_ADDR_ERR, `VEC_DMA_ADDR_ERR, 8'h09, 8'h00};
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        pin_reset(1'b1);
        pin_reset(1'b0);
        @(posedge mclk);
        nmi_pin <= 1'b1;
        vbr_write <= 1'b1;
        vbr_wdata <= base;
        @(posedge mclk);
        vbr_write <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("base write", vector_base, base);
        for (int i = 0; i < 3; i++) begin
            shuffle();
            @(posedge mclk);
            trap_imm <= {3'h1, 5'($random(seed))};
            trap_exec <= 1'b1;
            @(posedge mclk);
            trap_exec <= 1'b0;
            exc("trap", trap_imm, next_pc_in);
        end
        shuffle();
        decode(1'b1, 1'b0, 1'b0);
        exc("illegal", `VEC_GEN_ILLEGAL, decode_pc);
        shuffle();
        decode(1'b1, 1'b0, 1'b1);
        exc("slot undefined", `VEC_SLOT_ILLEGAL, slot_target_pc);
        shuffle();
        decode(1'b0, 1'b1, 1'b1);
        exc("slot pc write", `VEC_SLOT_ILLEGAL, slot_target_pc);
        for (int i = 0; i < 4; i++) begin
            shuffle();
            bus_check <= acc[i];
            nmi_req <= (i == 0);
            @(posedge mclk);
            bus_check <= '0;
            done <= (i != 1);
            decode(1'b0, 1'b0, 1'b0);
            chk("flag", 32'(addr_error), 32'(acc_vec[i] != 8'h00));
            if (i == 1) begin
                repeat (4) @(posedge mclk);
                chk("wait end", 32'(mem.req), 32'h0);
                done <= 1'b1;
            end
            if (acc_vec[i] == 8'h00) begin
                repeat (20) @(posedge mclk);
                chk("aligned access", 32'(busy), 32'h0);
            end else
                exc("addr error", acc_vec[i], next_pc_in);
            if (i == 0) begin
                decode(1'b0, 1'b0, 1'b0);
                exc("nmi", `VEC_NMI, next_pc_in);
                nmi_req <= 1'b0;
                user_break_req <= 1'b1;
                chk("nmi mask", 32'(int_mask_level), 32'hf);
                decode(1'b0, 1'b0, 1'b0);
                exc("break", `VEC_USER_BREAK, next_pc_in);
                user_break_req <= 1'b0;
            end
        end
        @(posedge mclk);
        irq_req <= 1'b1;
        irq_level <= 4'h3;
        irq_vector <= `VEC_EXT_INT_BASE;
        decode(1'b0, 1'b0, 1'b0);
        repeat (20) @(posedge mclk);
        chk("masked irq", 32'(busy), 32'h0);
        irq_req <= 1'b0;
        pin_reset(1'b1);
        give_verdict();
    end
endmodule : tb_top
